/* File: logic/pll_status_readback.sv */
`timescale 1ns/1ps
`include "pll_status_defs.svh"

// Summary of operation
// - Bit 4 shows second reference selected
// - Bit 3 shows oscillator above threshold
// - Bit 2 shows second reference above threshold
// - Bit 1 shows first reference above threshold
// - Bit 0 shows PLL digital lock
// - Bit 6 shows oscillator calibration finished
// - Bit 5 shows holdover state active
module pll_status_readback (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        lock_detect,
  input  wire logic        first_reference_input_ok,
  input  wire logic        second_reference_input_ok,
  input  wire logic        osc_above_threshold,
  input  wire logic        second_reference_input_selected,
  input  wire logic        holdover_active,
  input  wire logic        osc_cal_done,
  output logic             ref_threshold_sel,
  output logic             irq
);

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  pll_status_pkg::flags_t raw_flags;     // Unsynchronised monitor levels
  pll_status_pkg::flags_t flags_sync;    // Flags in the pclk domain
  pll_status_pkg::flags_t flags_prev_r;  // Last cycle's flags, for edges
  pll_status_pkg::flags_t flags_prev_nxt;
  pll_status_pkg::flags_t irq_stat_r;    // Sticky change events
  pll_status_pkg::flags_t irq_stat_nxt;
  pll_status_pkg::flags_t irq_en_r;      // Interrupt enables
  pll_status_pkg::flags_t irq_en_nxt;
  logic                   thr_sel_r;     // Reference threshold select
  logic                   thr_sel_nxt;
  logic                   irq_r;         // Registered interrupt level
  logic                   irq_nxt;
  logic [31:0]            prdata_r;      // Registered read data
  logic [31:0]            prdata_nxt;
  logic                   pready_r;      // Registered ready
  logic                   pready_nxt;
  logic                   pslverr_r;     // Registered error
  logic                   pslverr_nxt;
  logic                   setup;         // Setup phase seen
  logic                   access_done;   // Access phase completes now
  logic                   wr_clr;        // Clear register written now
  pll_status_pkg::flags_t changed;       // Flags that moved this cycle

  // ----------------------------------------------------------------------
  // Flag gathering and synchronisation
  // ----------------------------------------------------------------------
  // Each monitor lives in its own analog or reference domain
  always_comb begin
    raw_flags                        = '0;
    raw_flags[`PSR_BIT_LOCK]         = lock_detect;
    raw_flags[`PSR_BIT_FIRST_OK]     = first_reference_input_ok;
    raw_flags[`PSR_BIT_SECOND_OK]    = second_reference_input_ok;
    raw_flags[`PSR_BIT_OSC_OK]       = osc_above_threshold;
    raw_flags[`PSR_BIT_SECOND_SEL]   = second_reference_input_selected;
    raw_flags[`PSR_BIT_HOLDOVER]     = holdover_active;
    raw_flags[`PSR_BIT_CAL_DONE]     = osc_cal_done;
  end

  // Two flops per flag before any logic reads them
  flag_sync #(
    .WIDTH (`PSR_NUM_FLAGS)
  ) u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (raw_flags),
    .sync_out (flags_sync)
  );

  // ----------------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------------
  // Zero wait states: access completes in its first access cycle
  assign setup       = psel & ~penable;
  assign access_done = psel & penable & pready_r;
  assign wr_clr      = access_done & pwrite & (paddr == `PSR_OFF_IRQ_CLR);
  assign changed     = flags_sync ^ flags_prev_r;

  // ----------------------------------------------------------------------
  // Control and interrupt state, next values
  // ----------------------------------------------------------------------
  always_comb begin
    flags_prev_nxt = flags_sync;
    irq_en_nxt     = irq_en_r;
    thr_sel_nxt    = thr_sel_r;
    if (access_done && pwrite) begin
      // Status word is read only, so a write there changes nothing
      if (paddr == `PSR_OFF_IRQ_EN) begin
        irq_en_nxt = pwdata[`PSR_NUM_FLAGS-1:0];
      end else if (paddr == `PSR_OFF_THR_SEL) begin
        thr_sel_nxt = pwdata[0];
      end
    end
    // Clear first, then set: an edge in the clear cycle survives
    irq_stat_nxt = irq_stat_r;
    if (wr_clr) begin
      irq_stat_nxt = irq_stat_nxt & ~pwdata[`PSR_NUM_FLAGS-1:0];
    end
    irq_stat_nxt = irq_stat_nxt | changed;
    irq_nxt      = |(irq_stat_nxt & irq_en_nxt);
  end

  // ----------------------------------------------------------------------
  // APB response, next values
  // ----------------------------------------------------------------------
  always_comb begin
    prdata_nxt  = prdata_r;
    pready_nxt  = 1'b0;
    pslverr_nxt = 1'b0;
    if (setup) begin
      pready_nxt = 1'b1;
      prdata_nxt = '0;
      unique case (paddr)
        `PSR_OFF_STATUS: begin
          prdata_nxt[`PSR_NUM_FLAGS-1:0] = flags_sync;
        end
        `PSR_OFF_IRQ_STAT: begin
          prdata_nxt[`PSR_NUM_FLAGS-1:0] = irq_stat_r;
        end
        `PSR_OFF_IRQ_EN: begin
          prdata_nxt[`PSR_NUM_FLAGS-1:0] = irq_en_r;
        end
        `PSR_OFF_THR_SEL: begin
          prdata_nxt[0] = thr_sel_r;
        end
        `PSR_OFF_IRQ_CLR: begin
          // Write-only; reads as zero
          prdata_nxt = '0;
        end
        default: begin
          // Unmapped address answers with an error
          pslverr_nxt = 1'b1;
        end
      endcase
      // Writing the status word is an error too, never a change
      if (pwrite && paddr == `PSR_OFF_STATUS) begin
        pslverr_nxt = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_prev_r <= `PSR_RST_FLAGS;
      irq_stat_r   <= `PSR_RST_FLAGS;
      irq_en_r     <= `PSR_RST_IRQ_EN;
      thr_sel_r    <= `PSR_RST_THR_SEL;
      irq_r        <= 1'b0;
      prdata_r     <= 32'h0000_0000;
      pready_r     <= 1'b0;
      pslverr_r    <= 1'b0;
    end else begin
      flags_prev_r <= flags_prev_nxt;
      irq_stat_r   <= irq_stat_nxt;
      irq_en_r     <= irq_en_nxt;
      thr_sel_r    <= thr_sel_nxt;
      irq_r        <= irq_nxt;
      prdata_r     <= prdata_nxt;
      pready_r     <= pready_nxt;
      pslverr_r    <= pslverr_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs, all from flops
  // ----------------------------------------------------------------------
  assign prdata            = prdata_r;
  assign pready            = pready_r;
  assign pslverr           = pslverr_r;
  assign ref_threshold_sel = thr_sel_r;
  assign irq               = irq_r;

endmodule

/* File: common/pll_status_defs.svh */
`ifndef PLL_STATUS_DEFS_SVH
`define PLL_STATUS_DEFS_SVH

// ----------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------
// Status word index; one aligned word per index, so the byte address is
// four times it. Using the index itself would put the word off alignment.
`define PSR_IDX_STATUS   12'h01f
`define PSR_OFF_STATUS   12'h07c
`define PSR_OFF_IRQ_STAT 12'h100
`define PSR_OFF_IRQ_EN   12'h104
`define PSR_OFF_IRQ_CLR  12'h108
`define PSR_OFF_THR_SEL  12'h10c

// ----------------------------------------------------------------------
// Status word bit positions
// ----------------------------------------------------------------------
`define PSR_BIT_LOCK     0
`define PSR_BIT_FIRST_OK   1
`define PSR_BIT_SECOND_OK  2
`define PSR_BIT_OSC_OK     3
`define PSR_BIT_SECOND_SEL 4
`define PSR_BIT_HOLDOVER 5
`define PSR_BIT_CAL_DONE 6
`define PSR_NUM_FLAGS    7

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define PSR_RST_FLAGS    7'h00
`define PSR_RST_IRQ_EN   7'h00
`define PSR_RST_THR_SEL  1'h0

`endif

/* File: common/pll_status_pkg.sv */
package pll_status_pkg;
  // Flag vector type: one bit per status source
  typedef logic [6:0] flags_t;
endpackage

/* File: logic/flag_sync.sv */
`timescale 1ns/1ps
`include "pll_status_defs.svh"

// Two-flop synchroniser, one stage pair per flag
module flag_sync #(
  parameter int WIDTH = 7
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  // ----------------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------------
  if (WIDTH < 1) begin : g_bad_width
    $error("flag_sync width must be at least one");
  end

  logic [WIDTH-1:0] meta_r;    // First stage, read only by second
  logic [WIDTH-1:0] meta_nxt;  // Next first stage
  logic [WIDTH-1:0] sync_r;    // Second stage
  logic [WIDTH-1:0] sync_nxt;  // Next second stage

  // ----------------------------------------------------------------------
  // Next values
  // ----------------------------------------------------------------------
  always_comb begin
    meta_nxt = async_in;
    sync_nxt = meta_r;
  end

  // Register both stages; constants only under reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end

  assign sync_out = sync_r;

endmodule

/* File: testbench/pll_status_readback_asserts.sv */
`timescale 1ns/1ps
`include "pll_status_defs.svh"
// ----------------------------------------
// Status word checker
// ----------------------------------------
module pll_status_readback_asserts (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        lock_detect,
  input wire logic        first_reference_input_ok,
  input wire logic        second_reference_input_ok,
  input wire logic        osc_above_threshold,
  input wire logic        second_reference_input_selected,
  input wire logic        holdover_active,
  input wire logic        osc_cal_done
);
  logic [2:0] warm_r;   // Edges since reset, saturating
  logic [2:0] warm_nxt; // Next edge count
  logic       rd_stat;  // Answered status read
  // Synchroniser holds reset values early on, so skip those edges
  always_comb begin
    warm_nxt = (warm_r == 3'h7) ? warm_r : warm_r + 3'h1;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      warm_r <= 3'h0;
    end else begin
      warm_r <= warm_nxt;
    end
  end
  assign rd_stat = psel && penable && pready && !pwrite && paddr == `PSR_OFF_STATUS
                   && warm_r == 3'h7;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Source held long enough to cross the synchroniser
  property bit_p(int i, logic s);
    $stable(s)[*5] ##0 rd_stat |-> prdata[i] == s;
  endproperty
  a_sel_bit: assert property (bit_p(4, second_reference_input_selected)) else $error("sel bit");
  a_osc_bit: assert property (bit_p(3, osc_above_threshold)) else $error("osc bit");
  a_second_ok_bit: assert property (bit_p(2, second_reference_input_ok)) else $error("second ok bit");
  a_first_ok_bit: assert property (bit_p(1, first_reference_input_ok)) else $error("first ok bit");
  a_lock_bit: assert property (bit_p(0, lock_detect)) else $error("lock bit");
  a_cal_bit: assert property (bit_p(6, osc_cal_done)) else $error("cal bit");
  a_hold_bit: assert property (bit_p(5, holdover_active)) else $error("holdover bit");
  a_write_refused: assert property (psel && penable && pready && pwrite
    && paddr == `PSR_OFF_STATUS |-> pslverr) else $error("status write accepted");
  c_read: cover property (rd_stat);
  c_lock: cover property (rd_stat && prdata[0]);
  c_wr: cover property (pready && pwrite && pslverr);
endmodule

/* File: testbench/pll_status_readback_bench.sv */
`timescale 1ns/1ps
`include "pll_status_defs.svh"
module pll_status_readback_bench;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, thr, irq;
  logic [11:0] paddr;   // Bus address
  logic [31:0] pwdata;  // Write data
  logic [31:0] prdata;  // Read data
  logic [6:0]  src;     // Monitor inputs, bit order of the status word
  logic [31:0] rd;      // Last read data
  logic        err;     // Last error response
  int          n_mismatch, comparisons;
  pll_status_readback dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .lock_detect(src[0]), .first_reference_input_ok(src[1]),
    .second_reference_input_ok(src[2]), .osc_above_threshold(src[3]),
    .second_reference_input_selected(src[4]), .holdover_active(src[5]),
    .osc_cal_done(src[6]), .ref_threshold_sel(thr), .irq(irq));
  always #2.5 pclk = ~pclk;
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic close_out;
    if (n_mismatch == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %0t got %h want %h", $time, got, exp);
    end
  endtask
  // One APB transfer; bounded wait for the answer
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 40);
    if (k >= 40) begin
      n_mismatch++;
      $display("unexpected %0t no answer", $time);
      close_out();
    end
    rd = prdata; err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  // Settle the monitor inputs through the synchroniser
  task automatic set_src(input logic [6:0] v);
    src <= v;
    repeat (6) @(posedge pclk);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_flags; // Each flag alone, then none
    for (int i = 0; i < 8; i++) begin
      set_src(7'h01 << i);
      apb(1'b0, `PSR_OFF_STATUS, 32'h0);
      chk(rd, (32'h1 << i) & 32'h7f);
    end
  endtask
  task automatic t_refused; // Write to status and unmapped read
    set_src(7'h55);
    apb(1'b1, `PSR_OFF_STATUS, 32'h2a);
    chk({31'h0, err}, 32'h1);
    apb(1'b0, `PSR_OFF_STATUS, 32'h0);
    chk(rd, 32'h55);
    apb(1'b0, 12'h0f0, 32'h0);
    chk({31'h0, err}, 32'h1);
  endtask
  task automatic t_irq; // Raise, clear, mask
    set_src(7'h00);
    apb(1'b0, `PSR_OFF_IRQ_EN, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, `PSR_OFF_IRQ_CLR, 32'h7f);
    apb(1'b1, `PSR_OFF_IRQ_EN, 32'h1);
    set_src(7'h01);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, `PSR_OFF_IRQ_CLR, 32'h1);
    @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, `PSR_OFF_IRQ_EN, 32'h0);
    set_src(7'h03);
    chk({31'h0, irq}, 32'h0);
    apb(1'b0, `PSR_OFF_IRQ_STAT, 32'h0);
    chk(rd, 32'h2);
  endtask
  task automatic t_thr; // Threshold select reset value and write
    apb(1'b0, `PSR_OFF_THR_SEL, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, `PSR_OFF_THR_SEL, 32'h1);
    @(posedge pclk);
    chk({31'h0, thr}, 32'h1);
  endtask
  initial begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0;
    paddr = 12'h0; pwdata = 32'h0; src = 7'h0; n_mismatch = 0; comparisons = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_thr(); t_flags(); t_refused(); t_irq();
    close_out();
  end
endmodule
bind pll_status_readback pll_status_readback_asserts chk_u (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .lock_detect(lock_detect),
  .first_reference_input_ok(first_reference_input_ok),
  .second_reference_input_ok(second_reference_input_ok),
  .osc_above_threshold(osc_above_threshold),
  .second_reference_input_selected(second_reference_input_selected),
  .holdover_active(holdover_active), .osc_cal_done(osc_cal_done));
